// [hdl/iaec_ctrl.sv]
// Interrupt status, enable mask, acknowledge and master control over AHB-Lite.
// Assumes a single AHB-Lite master, word transfers only, one clock domain.
// Hardware sources are level inputs from other logic; they are synchronised.
`timescale 1ns/1ps
`include "iaec_map.svh"
`default_nettype none

// Summary of operation
// - Writing 1 to an acknowledge bit clears that latched status bit.
// - Acknowledge bits are self-clearing; nothing written is retained.
// - Masked active source keeps its status set until acknowledged.
// - Enabling an already active source raises the output if master on.
// - Acknowledge zeros, inactive or absent bits change nothing.
// - Bits 7-0 DAC, 8 DMA, 9 ADC FIFO, 10 counter, 11 I/O.
// - Set-enable write sets enable bits written as 1, others unchanged.
// - Clear-enable write clears enable bits written as 1, others unchanged.
// - Master bit 0 is global enable; when 0 output stays low.
// - Hardware enable bit resets to 0; then only software raises status.
// - Hardware enable 1 routes sources in and blocks software raising.
// - Once hardware enable is 1, later writes to it are ignored.
// - Master reads bits 0 and 1, zeros above; upper writes ignored.
// - Each pending bit is status AND enable.
// - Source events latch into status even while disabled.
// - Software status write of 1 raises that source; zeros no effect.
module iaec_ctrl
	import iaec_pkg::*;
#(
	parameter int NSRC = `IAEC_NUM_SRC
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic      [31:0]             hrdata,
	output logic                         hreadyout,
	output logic                         hresp,
	input  wire logic [NSRC-1:0]         srcIrq,
	output logic                         irqOut
);
	// Bus state
	logic                                addrValid;
	iaec_reg_type                        decReg;
	iaec_reg_type                        wrReg_q;
	logic                                wrPend_q;
	iaec_reg_type                        rdReg;
	logic [NSRC-1:0]                     wrBits;

	// Interrupt state
	logic [NSRC-1:0]                     status_q;
	logic [NSRC-1:0]                     enable_q;
	logic                                globalEn_q;
	logic                                hwEn_q;
	logic [NSRC-1:0]                     srcSync;
	logic [NSRC-1:0]                     srcPrev_q;
	logic [NSRC-1:0]                     hwRise;
	logic [NSRC-1:0]                     swRaise;
	logic [NSRC-1:0]                     ackClr;
	logic [NSRC-1:0]                     pendingView;

	// Maps a byte offset to the register it selects
	function automatic iaec_reg_type decodeOfs(
		input logic [`IAEC_ADDR_W-1:0] ofs
	);
		case (ofs)
			`IAEC_OFS_STATUS:  decodeOfs = IAEC_REG_STATUS;
			`IAEC_OFS_PENDING: decodeOfs = IAEC_REG_PENDING;
			`IAEC_OFS_ENABLE:  decodeOfs = IAEC_REG_ENABLE;
			`IAEC_OFS_ACK:     decodeOfs = IAEC_REG_ACK;
			`IAEC_OFS_ENSET:   decodeOfs = IAEC_REG_ENSET;
			`IAEC_OFS_ENCLR:   decodeOfs = IAEC_REG_ENCLR;
			`IAEC_OFS_MASTER:  decodeOfs = IAEC_REG_MASTER;
			default:           decodeOfs = IAEC_REG_NONE;
		endcase
	endfunction

	// Widens a source vector into a read word, reserved bits zero
	function automatic logic [31:0] toWord(input logic [NSRC-1:0] v);
		logic [31:0] w;
		w = `IAEC_ZERO_WORD;
		w[NSRC-1:0] = v;
		return w;
	endfunction

	// Hardware sources pass the three-flop conditioner
	iaec_src_sync #(
		.WIDTH  (NSRC)
	) u_src_sync (
		.clk    (clk),
		.rst    (rst),
		.asyncIn(srcIrq),
		.syncOut(srcSync)
	);

	// Valid address phase: selected, NONSEQ or SEQ, bus ready
	assign addrValid = hsel && hready &&
		(htrans == `IAEC_HTRANS_NONSEQ || htrans == `IAEC_HTRANS_SEQ);
	assign decReg = decodeOfs(haddr[`IAEC_ADDR_W-1:0]);
	assign rdReg  = (addrValid && !hwrite) ? decReg : IAEC_REG_NONE;

	// Write address phase held until data phase; hwdata arrives a cycle later
	always_ff @(posedge clk) begin
		if (rst) begin
			wrPend_q <= 1'b0;
			wrReg_q  <= IAEC_REG_NONE;
		end else begin
			wrPend_q <= addrValid && hwrite;
			wrReg_q  <= (addrValid && hwrite) ? decReg : IAEC_REG_NONE;
		end
	end

	// Only positions that have a source are ever acted on
	assign wrBits = hwdata[NSRC-1:0];

	// Zero-wait slave: always ready, always OKAY
	always_ff @(posedge clk) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Read data registered in the address phase, so it stands in data phase
	always_ff @(posedge clk) begin
		if (rst) begin
			hrdata <= `IAEC_ZERO_WORD;
		end else begin
			case (rdReg)
				IAEC_REG_STATUS:  hrdata <= toWord(status_q);
				IAEC_REG_PENDING: hrdata <= toWord(pendingView);
				IAEC_REG_ENABLE:  hrdata <= toWord(enable_q);
				IAEC_REG_MASTER: begin
					hrdata <= `IAEC_ZERO_WORD;
					hrdata[`IAEC_BIT_GLOBAL] <= globalEn_q;
					hrdata[`IAEC_BIT_HWEN]   <= hwEn_q;
				end
				// Write-only and unmapped locations read zero; ack leaves no trace
				default:          hrdata <= `IAEC_ZERO_WORD;
			endcase
		end
	end

	// Rising edges of the conditioned sources are the hardware events
	always_ff @(posedge clk) begin
		if (rst) begin
			srcPrev_q <= `IAEC_SRC_RESET;
		end else begin
			srcPrev_q <= srcSync;
		end
	end

	// Sources only count while hardware mode is on
	assign hwRise  = (srcSync & ~srcPrev_q) & {NSRC{hwEn_q}};
	// Software may raise status only before hardware mode
	assign swRaise = (wrPend_q && wrReg_q == IAEC_REG_STATUS && !hwEn_q) ?
		wrBits : '0;
	// Ones clear, zeros are ignored; clearing an idle bit is harmless
	assign ackClr  = (wrPend_q && wrReg_q == IAEC_REG_ACK) ?
		wrBits : '0;

	// Status latch: a new event in the clear cycle survives the acknowledge.
	// Enable plays no part here, so a masked event still latches.
	always_ff @(posedge clk) begin
		if (rst) begin
			status_q <= `IAEC_SRC_RESET;
		end else begin
			status_q <= (status_q & ~ackClr) | hwRise | swRaise;
		end
	end

	// Enable mask: plain write, or atomic set and clear without read-modify
	always_ff @(posedge clk) begin
		if (rst) begin
			enable_q <= `IAEC_SRC_RESET;
		end else if (wrPend_q) begin
			case (wrReg_q)
				IAEC_REG_ENABLE: enable_q <= wrBits;
				IAEC_REG_ENSET:  enable_q <= enable_q | wrBits;
				IAEC_REG_ENCLR:  enable_q <= enable_q & ~wrBits;
				default:         enable_q <= enable_q;
			endcase
		end
	end

	// Master control: global enable is free, hardware enable is write-once
	always_ff @(posedge clk) begin
		if (rst) begin
			globalEn_q <= 1'b0;
			hwEn_q     <= 1'b0;
		end else if (wrPend_q && wrReg_q == IAEC_REG_MASTER) begin
			globalEn_q <= hwdata[`IAEC_BIT_GLOBAL];
			// Once set it locks; only reset clears it again
			if (!hwEn_q) begin
				hwEn_q <= hwdata[`IAEC_BIT_HWEN];
			end
		end
	end

	assign pendingView = status_q & enable_q;

	// Output registered; enabling an active source raises it next edge
	always_ff @(posedge clk) begin
		if (rst) begin
			irqOut <= 1'b0;
		end else begin
			irqOut <= globalEn_q && (|pendingView);
		end
	end
endmodule
`default_nettype wire

// [shared/iaec_map.svh]
// Register offsets, field positions and reset values of the interrupt block.
// Assumes a 32-bit AHB-Lite register window; offsets are byte addresses.
`ifndef IAEC_MAP_SVH
`define IAEC_MAP_SVH

`define IAEC_ADDR_W        16
`define IAEC_OFS_STATUS    16'h2000
`define IAEC_OFS_PENDING   16'h2004
`define IAEC_OFS_ENABLE    16'h2008
`define IAEC_OFS_ACK       16'h200c
`define IAEC_OFS_ENSET     16'h2010
`define IAEC_OFS_ENCLR     16'h2014
`define IAEC_OFS_MASTER    16'h201c
`define IAEC_NUM_SRC       12
`define IAEC_BIT_GLOBAL    0
`define IAEC_BIT_HWEN      1
`define IAEC_SRC_RESET     12'h000
`define IAEC_ZERO_WORD     32'h0000_0000
`define IAEC_HTRANS_NONSEQ 2'h2
`define IAEC_HTRANS_SEQ    2'h3

`endif

// [shared/iaec_pkg.sv]
// Types shared by the interrupt acknowledge and enable control block.
// Assumes the register map header is compiled alongside.
`default_nettype none
package iaec_pkg;
	typedef enum logic [2:0] {
		IAEC_REG_NONE,
		IAEC_REG_STATUS,
		IAEC_REG_PENDING,
		IAEC_REG_ENABLE,
		IAEC_REG_ACK,
		IAEC_REG_ENSET,
		IAEC_REG_ENCLR,
		IAEC_REG_MASTER
	} iaec_reg_type;
endpackage
`default_nettype wire

// [hdl/iaec_src_sync.sv]
// Three-flop input conditioner for the asynchronous source lines.
// Assumes sources come from another clock or a pin; one clock, sync reset.
`timescale 1ns/1ps
`include "iaec_map.svh"
`default_nettype none
module iaec_src_sync #(
	parameter int WIDTH = `IAEC_NUM_SRC
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stage2_q;
	logic [WIDTH-1:0] stage3_q;

	// First stage feeds only the second; a change counts once two and three agree
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q   <= '0;
			stage2_q <= '0;
			stage3_q <= '0;
			syncOut  <= '0;
		end else begin
			meta_q   <= asyncIn;
			stage2_q <= meta_q;
			stage3_q <= stage2_q;
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2_q[i] == stage3_q[i]) begin
					syncOut[i] <= stage3_q[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// [dv/iaec_ctrl_checker.sv]
// Assertions on the register bus and interrupt output of iaec_ctrl.
// Assumes it is bound to iaec_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`include "iaec_map.svh"
`default_nettype none
module iaec_ctrl_checker (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        irqOut
);
	logic        wr_q, rd_q, glob_q, hw_q;
	logic [15:0] adr_q;
	logic [11:0] en_q;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Address phase capture, kept so data-phase checks know their target
	always_ff @(posedge clk) begin
		wr_q <= !rst && hsel && hready && htrans[1] && hwrite;
		rd_q <= !rst && hsel && hready && htrans[1] && !hwrite;
		adr_q <= haddr[15:0];
	end
	// Mirror of the enable mask and master bits, updated as the design does
	always_ff @(posedge clk) begin
		if (rst) begin
			{glob_q, hw_q, en_q} <= 14'h0;
		end else if (wr_q && hready) begin
			if (adr_q == `IAEC_OFS_ENABLE) en_q <= hwdata[11:0];
			if (adr_q == `IAEC_OFS_ENSET) en_q <= en_q | hwdata[11:0];
			if (adr_q == `IAEC_OFS_ENCLR) en_q <= en_q & ~hwdata[11:0];
			if (adr_q == `IAEC_OFS_MASTER) glob_q <= hwdata[0];
			if (adr_q == `IAEC_OFS_MASTER && hwdata[1]) hw_q <= 1'b1;
		end
	end
	a_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (!hresp)
		else $error("hresp not OKAY");
	a_ack_zero: assert property (rd_q && adr_q == `IAEC_OFS_ACK |->
		hrdata == 32'h0) else $error("ack location read nonzero");
	a_master_read: assert property (rd_q && adr_q == `IAEC_OFS_MASTER |->
		hrdata == {30'h0, $past(hw_q), $past(glob_q)})
		else $error("master read wrong");
	a_enable_read: assert property (rd_q && adr_q == `IAEC_OFS_ENABLE |->
		hrdata == {20'h0, $past(en_q)}) else $error("enable mask wrong");
	a_upper_zero: assert property (rd_q |-> hrdata[31:12] == 20'h0)
		else $error("reserved bits read nonzero");
	a_pend_masked: assert property (rd_q && adr_q == `IAEC_OFS_PENDING |->
		(hrdata[11:0] & ~$past(en_q)) == 12'h0) else $error("pending unmasked");
	a_irq_global: assert property (irqOut |-> $past(glob_q))
		else $error("irqOut high without global enable");
	a_global_off: assert property (wr_q && adr_q == `IAEC_OFS_MASTER &&
		!hwdata[0] |-> ##2 !irqOut) else $error("irqOut stayed high");
endmodule
bind iaec_ctrl iaec_ctrl_checker u_chk (.clk(clk), .rst(rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .irqOut(irqOut));
`default_nettype wire

// [dv/test_interrupt_ack_enable_ctrl.sv]
// Self-checking bench for iaec_ctrl: AHB-Lite register traffic,
// software and hardware interrupt sources, and the interrupt output.
// Assumes the map header and the package are compiled first.
`timescale 1ns/1ps
`include "iaec_map.svh"
`default_nettype none
module test_interrupt_ack_enable_ctrl;
	logic        clk, rst, hsel, hwrite, hreadyout, hresp, irqOut, rdPh;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [11:0] srcIrq, v, e, s;
	logic [31:0] expQ[$];
	int          err_count, n_tests, seed;
	iaec_ctrl u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .srcIrq(srcIrq), .irqOut(irqOut));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One single transfer; the idle edge first avoids a stale read-back
	task automatic xfer(input logic w, input logic [15:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {16'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		rdPh <= !w;
		if (!w) expQ.push_back(d);
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdPh <= 1'b0;
	endtask
	// Output is registered, so it is looked at two edges after a change
	task automatic irqchk(input logic exp);
		repeat (2) @(posedge clk);
		#1 chk({31'h0, irqOut}, {31'h0, exp});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Each read result is paired with the oldest noted expectation
	always @(posedge clk) begin
		if (rdPh === 1'b1 && expQ.size() > 0) chk(hrdata, expQ.pop_front());
	end
	initial begin
		#100000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		{hsel, hwrite, rdPh, rst} = 4'h1;
		{htrans, haddr, hwdata, srcIrq} = 78'h0;
		{err_count, n_tests, seed} = {32'h0, 32'h0, 32'd65921};
		v = 12'($random(seed)) | 12'h1;
		e = 12'($random(seed)) | 12'h1;
		s = 12'($random(seed)) | 12'h1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		srcIrq <= 12'($random(seed));
		xfer(1'b0, `IAEC_OFS_MASTER, 32'h0);
		xfer(1'b0, 16'h2018, 32'h0);
		xfer(1'b1, `IAEC_OFS_STATUS, {20'hfffff, v});
		xfer(1'b0, `IAEC_OFS_STATUS, {20'h0, v});
		xfer(1'b0, `IAEC_OFS_PENDING, 32'h0);
		xfer(1'b1, `IAEC_OFS_ENSET, {20'hfffff, e});
		xfer(1'b0, `IAEC_OFS_ENABLE, {20'h0, e});
		xfer(1'b0, `IAEC_OFS_PENDING, {20'h0, v & e});
		irqchk(1'b0);
		xfer(1'b1, `IAEC_OFS_MASTER, 32'h1);
		irqchk(1'b1);
		xfer(1'b1, `IAEC_OFS_ENCLR, 32'hffff_f001);
		xfer(1'b0, `IAEC_OFS_ENABLE, {20'h0, e & 12'hffe});
		xfer(1'b0, `IAEC_OFS_STATUS, {20'h0, v});
		xfer(1'b1, `IAEC_OFS_ACK, 32'hffff_f001);
		xfer(1'b1, `IAEC_OFS_ACK, 32'h0);
		xfer(1'b0, `IAEC_OFS_STATUS, {20'h0, v & 12'hffe});
		xfer(1'b0, `IAEC_OFS_ACK, 32'h0);
		srcIrq <= 12'h0;
		repeat (8) @(posedge clk);
		xfer(1'b1, `IAEC_OFS_MASTER, 32'hffff_fffe);
		xfer(1'b0, `IAEC_OFS_MASTER, 32'h2);
		irqchk(1'b0);
		xfer(1'b1, `IAEC_OFS_MASTER, 32'h1);
		xfer(1'b0, `IAEC_OFS_MASTER, 32'h3);
		xfer(1'b1, `IAEC_OFS_ACK, 32'hfff);
		xfer(1'b1, `IAEC_OFS_STATUS, 32'hfff);
		xfer(1'b0, `IAEC_OFS_STATUS, 32'h0);
		srcIrq <= s;
		repeat (8) @(posedge clk);
		xfer(1'b0, `IAEC_OFS_STATUS, {20'h0, s});
		irqchk(|(s & e & 12'hffe));
		tally_and_finish();
	end
endmodule
`default_nettype wire
